// *** verilog/host_uart_pkg.sv ***
/*
  Constants, types and timing figures shared by the host serial block and its FIFO.
  Assumes a single 40 MHz system clock and synchronous active-high reset.
*/
// Behaviour
// (R1) All host traffic in both directions travels as SLIP frames on the host serial port.
// (R2) The host serial port runs at 115,200 or 230,400 bit/s with no hardware flow control.
// (R3) Loader mode is entered when boot_request_n stays low throughout a low reset pulse.
// (R4) The host keeps boot_request_n low after reset release until the loader answers.
// (R5) A later reset pulse with boot_request_n high leaves loader mode for normal operation.
// (R6) In loader mode, firmware images from the host arrive over the host serial port.
// (R7) The host serial port carries data traffic, control commands and firmware updates.
// (R8) A second, separate serial port carries only debug traffic.
// (R9) While system_reset_n is low all operation halts and the block reinitialises.
// (R10) The driving party holds system_reset_n low for at least eight system clocks.
// (R11) After system_reset_n returns high, operation resumes within eight clocks.
// (R12) Characters use one start bit, eight data bits LSB first, no parity, one stop bit.
// (R13) The boot_request_n level is latched at the reset pin rising edge until next reset.
package host_uart_pkg;

  // ----------------------------------------------------------------
  // Clock and bit rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BAUD_SLOW_BPS = 115_200;
  localparam int unsigned BAUD_FAST_BPS = 230_400;
  localparam logic [15:0] DIV_SLOW = 16'((CLK_HZ + BAUD_SLOW_BPS / 2) / BAUD_SLOW_BPS);
  localparam logic [15:0] DIV_FAST = 16'((CLK_HZ + BAUD_FAST_BPS / 2) / BAUD_FAST_BPS);

  // ----------------------------------------------------------------
  // Character framing
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [3:0] TX_BITS_AFTER_START = 4'h9;
  localparam logic [3:0] RX_STOP_IDX = 4'h9;

  // ----------------------------------------------------------------
  // SLIP special characters
  // ----------------------------------------------------------------
  localparam logic [7:0] SLIP_END = 8'hc0;
  localparam logic [7:0] SLIP_ESC = 8'hdb;
  localparam logic [7:0] SLIP_ESC_END = 8'hdc;
  localparam logic [7:0] SLIP_ESC_ESC = 8'hdd;

  // ----------------------------------------------------------------
  // Reset timing (cycles)
  // ----------------------------------------------------------------
  localparam int RESET_MIN_CYCLES = 8;
  localparam int RUN_LIMIT_CYCLES = 8;
  localparam logic [2:0] RUN_DELAY = 3'h4;

  // ----------------------------------------------------------------
  // Ports and buffering
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam int HOST_PORT = 0;
  localparam int DEBUG_PORT = 1;
  localparam int FIFO_DEPTH = 8;
  localparam int RX_WORD_W = BYTE_W + 2;

  // ----------------------------------------------------------------
  // SLIP encoder states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ENC_IDLE = 2'b00,
    ENC_DATA = 2'b01,
    ENC_ESC2 = 2'b11,
    ENC_END = 2'b10
  } enc_state_t;

endpackage

// *** verilog/stream_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock with synchronous reset.
*/
module stream_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic doPush;
  logic doPop;

  // Handshake terms
  assign inReady = (count != FULL);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // Storage
  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= wrPtr + PW'(1);
      end
      if (doPop)
      begin
        rdPtr <= rdPtr + PW'(1);
      end
      if (doPush && !doPop)
      begin
        count <= count + CW'(1);
      end
      else if (doPop && !doPush)
      begin
        count <= count - CW'(1);
      end
    end
  end

endmodule

// *** verilog/host_uart_boot_select.sv ***
/*
  Host serial port with SLIP framing, debug serial port and boot-mode selection.
  Assumes all pin inputs are synchronous to clk and that the host obeys reset timing.
*/
module host_uart_boot_select (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reset and boot pins
  input wire logic system_reset_n,
  input wire logic boot_request_n,
  input wire logic rateFast,
  // Host serial port lines
  input wire logic hostRxd,
  output logic hostTxd,
  // Debug serial port lines
  input wire logic debugRxd,
  output logic debugTxd,
  // Status
  output logic running,
  output logic bootMode,
  output logic rxError,
  // Frames to send to host
  input wire logic [host_uart_pkg::BYTE_W-1:0] txData,
  input wire logic txLast,
  input wire logic txValid,
  output logic txReady,
  // Frames received from host
  output logic [host_uart_pkg::BYTE_W-1:0] rxData,
  output logic rxLast,
  output logic rxLoader,
  output logic rxValid,
  input wire logic rxReady,
  // Debug byte stream
  input wire logic [host_uart_pkg::BYTE_W-1:0] dbgTxData,
  input wire logic dbgTxValid,
  output logic dbgTxReady,
  output logic [host_uart_pkg::BYTE_W-1:0] dbgRxData,
  output logic dbgRxValid
);
  import host_uart_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic pinPrev;
  logic bootHeld;
  logic [2:0] runCnt;
  logic holdRst;
  logic [15:0] bitDiv;
  logic [7:0] txByteV [NUM_PORTS];
  logic txGoV [NUM_PORTS];
  logic txBusy [NUM_PORTS];
  logic txLine [NUM_PORTS];
  logic [15:0] txCnt [NUM_PORTS];
  logic rxLine [NUM_PORTS];
  logic [7:0] rxByteV [NUM_PORTS];
  logic rxStb [NUM_PORTS];
  enc_state_t encState;
  logic [7:0] holdByte;
  logic holdLast;
  logic [7:0] escSub;
  logic escaping;
  logic pendValid;
  logic [7:0] pendByte;
  logic pushValid;
  logic [RX_WORD_W-1:0] pushData;
  logic pushReady;
  logic [RX_WORD_W-1:0] popData;
  logic decData;
  logic decErr;
  logic [7:0] decByte;
  logic encFree;

  // ----------------------------------------------------------------
  // Reset pin, run control and boot selection
  // ----------------------------------------------------------------
  // Core halts while the pin is low and restarts a fixed delay after release
  always_ff @(posedge clk)
  begin
    if (sys_rst || !system_reset_n) // [R9]
    begin
      runCnt <= 3'h0;
      running <= 1'b0;
    end
    else if (!running)
    begin
      runCnt <= runCnt + 3'h1;
      running <= (runCnt == RUN_DELAY - 3'h1); // [R11]
    end
  end

  // Engines clear on the first low cycle of the pin, not one cycle later
  assign holdRst = sys_rst || !system_reset_n || !running; // [R9]

  // Boot request must stay low for the whole low pulse, then is latched at the rise
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinPrev <= 1'b1;
      bootHeld <= 1'b0;
      bootMode <= 1'b0;
    end
    else
    begin
      pinPrev <= system_reset_n;
      if (!system_reset_n)
      begin
        bootHeld <= !boot_request_n && (bootHeld || pinPrev); // [R3]
      end
      if (system_reset_n && !pinPrev)
      begin
        bootMode <= bootHeld && !boot_request_n; // [R13] [R5]
      end
    end
  end

  // Bit period chosen from the two supported rates
  assign bitDiv = rateFast ? DIV_FAST : DIV_SLOW; // [R2]

  // ----------------------------------------------------------------
  // Serial engines, one per port
  // ----------------------------------------------------------------
  assign rxLine[HOST_PORT] = hostRxd;
  assign rxLine[DEBUG_PORT] = debugRxd;
  assign hostTxd = txLine[HOST_PORT];
  assign debugTxd = txLine[DEBUG_PORT];

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    logic [8:0] txShift;
    logic [3:0] txLeft;
    logic rxActive;
    logic [3:0] rxIdx;
    logic [15:0] rxCnt;
    logic [7:0] rxShift;

    // Transmitter: start bit, eight data bits LSB first, stop bit
    always_ff @(posedge clk)
    begin
      if (holdRst)
      begin
        txShift <= 9'h1ff;
        txLeft <= 4'h0;
        txCnt[p] <= 16'h0;
        txBusy[p] <= 1'b0;
        txLine[p] <= 1'b1;
      end
      else if (!txBusy[p] && txGoV[p])
      begin
        txShift <= {1'b1, txByteV[p]}; // [R12]
        txLeft <= TX_BITS_AFTER_START;
        txCnt[p] <= bitDiv - 16'h1;
        txBusy[p] <= 1'b1;
        txLine[p] <= 1'b0;
      end
      else if (txBusy[p])
      begin
        if (txCnt[p] != 16'h0)
        begin
          txCnt[p] <= txCnt[p] - 16'h1;
        end
        else if (txLeft == 4'h0)
        begin
          txBusy[p] <= 1'b0;
        end
        else
        begin
          txLine[p] <= txShift[0];
          txShift <= {1'b1, txShift[8:1]};
          txLeft <= txLeft - 4'h1;
          txCnt[p] <= bitDiv - 16'h1;
        end
      end
    end

    // Receiver: samples mid-bit, drops false starts and bad stop bits
    always_ff @(posedge clk)
    begin
      if (holdRst)
      begin
        rxActive <= 1'b0;
        rxIdx <= 4'h0;
        rxCnt <= 16'h0;
        rxShift <= 8'h00;
        rxByteV[p] <= 8'h00;
        rxStb[p] <= 1'b0;
      end
      else
      begin
        rxStb[p] <= 1'b0;
        if (!rxActive)
        begin
          if (!rxLine[p])
          begin
            rxActive <= 1'b1;
            rxIdx <= 4'h0;
            rxCnt <= {1'b0, bitDiv[15:1]} - 16'h1;
          end
        end
        else if (rxCnt != 16'h0)
        begin
          rxCnt <= rxCnt - 16'h1;
        end
        else
        begin
          rxCnt <= bitDiv - 16'h1;
          rxIdx <= rxIdx + 4'h1;
          if (rxIdx == 4'h0)
          begin
            rxActive <= !rxLine[p];
          end
          else if (rxIdx != RX_STOP_IDX)
          begin
            rxShift <= {rxLine[p], rxShift[7:1]}; // [R12]
          end
          else
          begin
            rxActive <= 1'b0;
            rxStb[p] <= rxLine[p];
            rxByteV[p] <= rxShift;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // SLIP encoder toward the host
  // ----------------------------------------------------------------
  assign encFree = !txBusy[HOST_PORT] && !txGoV[HOST_PORT];

  // Special bytes are escaped and every frame is closed by an END byte
  always_ff @(posedge clk)
  begin
    if (holdRst)
    begin
      encState <= ENC_IDLE;
      txReady <= 1'b0;
      txGoV[HOST_PORT] <= 1'b0;
      txByteV[HOST_PORT] <= 8'h00;
      holdByte <= 8'h00;
      holdLast <= 1'b0;
      escSub <= 8'h00;
    end
    else
    begin
      txGoV[HOST_PORT] <= 1'b0;
      unique case (encState)
        ENC_IDLE:
        begin
          txReady <= 1'b1;
          if (txValid && txReady)
          begin
            txReady <= 1'b0;
            holdByte <= txData;
            holdLast <= txLast;
            encState <= ENC_DATA;
          end
        end
        ENC_DATA:
        begin
          if (encFree)
          begin
            txGoV[HOST_PORT] <= 1'b1;
            if (holdByte == SLIP_END || holdByte == SLIP_ESC) // [R1]
            begin
              txByteV[HOST_PORT] <= SLIP_ESC;
              escSub <= (holdByte == SLIP_END) ? SLIP_ESC_END : SLIP_ESC_ESC;
              encState <= ENC_ESC2;
            end
            else
            begin
              txByteV[HOST_PORT] <= holdByte;
              encState <= holdLast ? ENC_END : ENC_IDLE;
            end
          end
        end
        ENC_ESC2:
        begin
          if (encFree)
          begin
            txGoV[HOST_PORT] <= 1'b1;
            txByteV[HOST_PORT] <= escSub;
            encState <= holdLast ? ENC_END : ENC_IDLE;
          end
        end
        ENC_END:
        begin
          if (encFree)
          begin
            txGoV[HOST_PORT] <= 1'b1;
            txByteV[HOST_PORT] <= SLIP_END; // [R1]
            encState <= ENC_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // SLIP decoder from the host
  // ----------------------------------------------------------------
  // Classify one received character
  always_comb
  begin
    decData = 1'b0;
    decErr = 1'b0;
    decByte = rxByteV[HOST_PORT];
    if (rxByteV[HOST_PORT] != SLIP_END)
    begin
      if (escaping)
      begin
        decData = (rxByteV[HOST_PORT] == SLIP_ESC_END) || (rxByteV[HOST_PORT] == SLIP_ESC_ESC);
        decErr = !decData;
        decByte = (rxByteV[HOST_PORT] == SLIP_ESC_END) ? SLIP_END : SLIP_ESC;
      end
      else
      begin
        decData = (rxByteV[HOST_PORT] != SLIP_ESC);
      end
    end
  end

  // One byte is held back so the frame's last byte can be marked; each word is tagged
  // with the mode so loader images and normal traffic share one path
  always_ff @(posedge clk)
  begin
    if (holdRst)
    begin
      escaping <= 1'b0;
      pendValid <= 1'b0;
      pendByte <= 8'h00;
      pushValid <= 1'b0;
      pushData <= '0;
      rxError <= 1'b0;
    end
    else
    begin
      pushValid <= 1'b0;
      rxError <= pushValid && !pushReady; // Overrun: no flow control to stall the host
      if (rxStb[HOST_PORT])
      begin
        escaping <= !escaping && (rxByteV[HOST_PORT] == SLIP_ESC);
        if (decErr)
        begin
          rxError <= 1'b1;
        end
        if (rxByteV[HOST_PORT] == SLIP_END || decData) // [R1]
        begin
          pushValid <= pendValid;
          pushData <= {bootMode, !decData, pendByte}; // [R6] [R7]
          pendValid <= decData;
          pendByte <= decByte;
        end
      end
    end
  end

  stream_fifo #(
    .WIDTH(RX_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst(holdRst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(popData)
  );

  assign rxLoader = popData[BYTE_W+1];
  assign rxLast = popData[BYTE_W];
  assign rxData = popData[BYTE_W-1:0];

  // ----------------------------------------------------------------
  // Debug port: plain bytes, never mixed with host traffic
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (holdRst)
    begin
      dbgTxReady <= 1'b0;
      txGoV[DEBUG_PORT] <= 1'b0;
      txByteV[DEBUG_PORT] <= 8'h00;
      dbgRxValid <= 1'b0;
      dbgRxData <= 8'h00;
    end
    else
    begin
      txGoV[DEBUG_PORT] <= dbgTxValid && dbgTxReady; // [R8]
      dbgRxValid <= rxStb[DEBUG_PORT];
      if (rxStb[DEBUG_PORT])
      begin
        dbgRxData <= rxByteV[DEBUG_PORT];
      end
      if (dbgTxValid && dbgTxReady)
      begin
        txByteV[DEBUG_PORT] <= dbgTxData;
        dbgTxReady <= 1'b0;
      end
      else if (!txBusy[DEBUG_PORT] && !txGoV[DEBUG_PORT])
      begin
        dbgTxReady <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions and cover points
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RESET_HALT: assert property (!system_reset_n |=> !running && !txReady) // [R9]
    else $error("core still active while reset pin low");
  AST_RUN_LATENCY: assert property (($rose(system_reset_n) ##1 system_reset_n [*4]) |-> running) // [R11]
    else $error("core not running four cycles after reset release");
  AST_BOOT_ENTRY: assert property ($rose(system_reset_n) && bootHeld && !boot_request_n |=> bootMode) // [R3]
    else $error("loader mode not entered");
  AST_BOOT_LEAVE: assert property ($rose(system_reset_n) && boot_request_n |=> !bootMode) // [R5]
    else $error("loader mode kept with boot request high");
  AST_BOOT_STABLE: assert property (!$rose(system_reset_n) |=> $stable(bootMode)) // [R13]
    else $error("boot mode changed outside reset release");
  AST_NO_RAW_END: assert property (txGoV[0] && $past(encState) == ENC_DATA |-> txByteV[0] != SLIP_END) // [R1]
    else $error("unescaped END byte sent inside frame");
  AST_ESC_PAIR: assert property (encState == ENC_DATA && encFree && holdByte == SLIP_ESC
    |=> encState == ENC_ESC2 && escSub == SLIP_ESC_ESC ##1 !txGoV[0] [*1]) // [R1]
    else $error("escape byte not followed by substitute");
  AST_BIT_TIME: assert property (!txBusy[0] && txGoV[0] |=> txCnt[0] == $past(bitDiv) - 16'h1) // [R2]
    else $error("bit period not taken from selected rate");
  AST_DEBUG_SEPARATE: assert property (txGoV[1] |-> $past(dbgTxValid && dbgTxReady)) // [R8]
    else $error("debug port sent a byte not from the debug stream");
  AST_LOADER_TAG: assert property (rxValid |-> rxLoader == bootMode) // [R6]
    else $error("received word carries wrong mode tag");

  COV_LOADER_ENTRY: cover property ($rose(bootMode));
  COV_FRAME_END: cover property (rxValid && rxReady && rxLast);
  COV_ESCAPE_SENT: cover property (encState == ENC_ESC2 ##1 txGoV[0]);

endmodule

// *** verif/serial_host_model.sv ***
/*
  Host processor model for one asynchronous serial line: sends and decodes characters.
  Assumes rateFast selects the bit time and changes only while both directions are idle.
*/
module serial_host_model (
  // Clock and rate select
  input wire logic clk,
  input wire logic rateFast,
  // Serial lines
  input wire logic lineIn,
  output logic lineOut
);
  timeunit 1ns;
  timeprecision 100ps;
  import host_uart_pkg::*;

  logic [7:0] rxQ[$];
  logic [7:0] rxByte;
  int badStops = 0;

  // Bit time in clocks; the link has no handshake lines at all
  function automatic int bitTime();
    return rateFast ? int'(DIV_FAST) : int'(DIV_SLOW);
  endfunction

  // Line rests high between characters
  initial lineOut = 1'b1;

  // Start bit, eight data bits LSB first, stop bit, each one bit time
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      lineOut = frame[i];
      repeat (bitTime() - 1) @(negedge clk);
    end
  endtask

  // Receiver: find start edge, sample mid-bit, keep only well-stopped characters
  always
  begin
    @(negedge clk);
    if (lineIn === 1'b0)
    begin
      repeat (bitTime() / 2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bitTime()) @(negedge clk);
        rxByte[i] = lineIn;
      end
      repeat (bitTime()) @(negedge clk);
      if (lineIn === 1'b1)
        rxQ.push_back(rxByte);
      else
        badStops++;
    end
  end
endmodule

// *** verif/host_uart_boot_select_tb.sv ***
/*
  Self-checking bench for the host serial block: framing, rates, boot select, debug port.
  Assumes one serial host model on each serial port and a 40 MHz clock.
*/
module host_uart_boot_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import host_uart_pkg::*;

  logic clk, sys_rst, system_reset_n, boot_request_n, rateFast;
  logic hostRxd, hostTxd, debugRxd, debugTxd, running, bootMode, rxError;
  logic [7:0] txData, rxData, dbgTxData, dbgRxData;
  logic txLast, txValid, txReady, rxLast, rxLoader, rxValid, rxReady;
  logic dbgTxValid, dbgTxReady, dbgRxValid;
  logic [9:0] rxW[$];
  logic [7:0] dbgQ[$];
  int error_cnt = 0;
  int num_checks = 0;
  int rxErrs = 0;
  int cycles = 0;

  host_uart_boot_select DUT (.clk(clk), .sys_rst(sys_rst), .system_reset_n(system_reset_n),
    .boot_request_n(boot_request_n), .rateFast(rateFast), .hostRxd(hostRxd),
    .hostTxd(hostTxd), .debugRxd(debugRxd), .debugTxd(debugTxd), .running(running),
    .bootMode(bootMode), .rxError(rxError), .txData(txData), .txLast(txLast),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxLast(rxLast),
    .rxLoader(rxLoader), .rxValid(rxValid), .rxReady(rxReady), .dbgTxData(dbgTxData),
    .dbgTxValid(dbgTxValid), .dbgTxReady(dbgTxReady), .dbgRxData(dbgRxData),
    .dbgRxValid(dbgRxValid));
  serial_host_model host (.clk(clk), .rateFast(rateFast), .lineIn(hostTxd), .lineOut(hostRxd));
  serial_host_model dbgHost (.clk(clk), .rateFast(rateFast), .lineIn(debugTxd),
    .lineOut(debugRxd));

  // ------------------------------------------------------------
  // Clock, capture and watchdog
  // ------------------------------------------------------------
  always #12.5 clk = ~clk;

  // Record handshakes and pulses as the block presents them
  always @(posedge clk)
  begin
    if (rxValid === 1'b1 && rxReady === 1'b1) rxW.push_back({rxLoader, rxLast, rxData});
    if (rxError === 1'b1) rxErrs++;
    if (dbgRxValid === 1'b1) dbgQ.push_back(dbgRxData);
    cycles++;
    if (cycles == 100000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Pulse the reset pin for eight clocks with a chosen boot level
  task automatic pulse_reset(input logic boot, input logic expBoot);
    int n;
    @(negedge clk);
    boot_request_n = boot;
    @(negedge clk);
    system_reset_n = 1'b0;
    repeat (8) @(negedge clk);
    check("running held", running, 16'h0);
    check("txReady held", txReady, 16'h0);
    system_reset_n = 1'b1;
    n = 0;
    while (running !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check("run delay ok", 16'(n <= 8), 16'h1);
    check("bootMode", bootMode, 16'(expBoot));
    check("host line idle", hostTxd, 16'h1);
  endtask

  task automatic tx_byte(input logic [7:0] d, input logic last);
    int n;
    @(negedge clk);
    txData = d;
    txLast = last;
    txValid = 1'b1;
    n = 0;
    while (txReady !== 1'b1 && n < 30000)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    txValid = 1'b0;
  endtask

  // Wait until the two models together hold n characters
  task automatic wait_bytes(input int n);
    int k;
    k = 0;
    while (host.rxQ.size() + dbgHost.rxQ.size() < n && k < 30000)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic expect_host(input logic [7:0] e[$]);
    check("host count", 16'(host.rxQ.size()), 16'(e.size()));
    foreach (e[i]) if (host.rxQ.size() > 0) check("host byte", host.rxQ.pop_front(), e[i]);
    host.rxQ.delete();
  endtask

  task automatic expect_words(input logic [9:0] e[$]);
    repeat (20) @(negedge clk);
    check("word count", 16'(rxW.size()), 16'(e.size()));
    foreach (e[i]) if (rxW.size() > 0) check("rx word", rxW.pop_front(), e[i]);
    rxW.delete();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Frame to host with both special bytes escaped and a closing END
  task automatic test_tx_frame();
    tx_byte(8'h11, 1'b0);
    tx_byte(8'hc0, 1'b0);
    tx_byte(8'hdb, 1'b0);
    tx_byte(8'h22, 1'b1);
    wait_bytes(7);
    expect_host('{8'h11, 8'hdb, 8'hdc, 8'hdb, 8'hdd, 8'h22, 8'hc0});
    check("debug silent", 16'(dbgHost.rxQ.size()), 16'h0);
    check("host stop bits", 16'(host.badStops), 16'h0);
  endtask

  // One byte at the slower rate; a wrong divisor garbles it
  task automatic test_slow_rate();
    @(negedge clk);
    rateFast = 1'b0;
    tx_byte(8'h5a, 1'b1);
    wait_bytes(2);
    expect_host('{8'h5a, 8'hc0});
    @(negedge clk);
    rateFast = 1'b1;
  endtask

  // Escaped bytes decoded, bad escape dropped and flagged
  task automatic test_rx_frame();
    logic [7:0] s[$];
    s = '{8'h41, 8'hdb, 8'hdc, 8'hdb, 8'hdd, 8'hc0, 8'h55, 8'hdb, 8'h41, 8'hc0};
    rxErrs = 0;
    foreach (s[i]) host.sendByte(s[i]);
    expect_words('{10'h041, 10'h0c0, 10'h1db, 10'h155});
    check("escape error", 16'(rxErrs), 16'h1);
  endtask

  // Debug port carries raw bytes only and leaves the host port alone
  task automatic test_debug();
    @(negedge clk);
    dbgTxData = 8'hc0;
    dbgTxValid = 1'b1;
    while (dbgTxReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    dbgTxValid = 1'b0;
    wait_bytes(1);
    check("debug out count", 16'(dbgHost.rxQ.size()), 16'h1);
    if (dbgHost.rxQ.size() > 0) check("debug out", dbgHost.rxQ.pop_front(), 16'hc0);
    dbgQ.delete();
    dbgHost.sendByte(8'hc0);
    repeat (20) @(negedge clk);
    check("debug in count", 16'(dbgQ.size()), 16'h1);
    if (dbgQ.size() > 0) check("debug in", dbgQ.pop_front(), 16'hc0);
    check("host untouched", 16'(rxW.size() + host.rxQ.size()), 16'h0);
    check("debug stop bits", 16'(dbgHost.badStops), 16'h0);
  endtask

  // Fill the receive buffer past eight words with the reader stalled, then drain
  task automatic test_overflow();
    logic [9:0] e[$];
    @(negedge clk);
    rxReady = 1'b0;
    rxErrs = 0;
    for (int i = 1; i <= 10; i++) host.sendByte(8'(i));
    repeat (20) @(negedge clk);
    check("overrun flagged", 16'(rxErrs), 16'h1);
    check("full valid", rxValid, 16'h1);
    rxReady = 1'b1;
    for (int i = 1; i <= 8; i++) e.push_back(10'(i));
    expect_words(e);
    check("drained", rxValid, 16'h0);
  endtask

  // Loader entry with boot low, latch, then normal mode after a reset with boot high
  task automatic test_boot();
    pulse_reset(1'b0, 1'b1);
    host.sendByte(8'h41);
    host.sendByte(8'hc0);
    expect_words('{10'h341});
    @(negedge clk);
    boot_request_n = 1'b1;
    repeat (4) @(negedge clk);
    check("boot latched", bootMode, 16'h1);
    pulse_reset(1'b1, 1'b0);
    host.sendByte(8'h42);
    host.sendByte(8'hc0);
    expect_words('{10'h142});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    system_reset_n = 1'b1;
    boot_request_n = 1'b1;
    rateFast = 1'b1;
    txData = 8'h00;
    txLast = 1'b0;
    txValid = 1'b0;
    rxReady = 1'b1;
    dbgTxData = 8'h00;
    dbgTxValid = 1'b0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    pulse_reset(1'b1, 1'b0);
    test_tx_frame();
    test_slow_rate();
    test_rx_frame();
    test_debug();
    test_overflow();
    test_boot();
    stop_test();
  end
endmodule
